//--- dv/epi_pin_src.sv
// Pin source model for the pin interrupt block
`timescale 1ns/1ps
module epi_pin_src (
    input wire logic clk,
    input wire logic holdLow,
    output logic pinN
);
    // Pull-up keeps the pin high when idle
    initial pinN = 1'b1;
    // Pulls low only on request, one edge late
    always @(posedge clk) pinN <= !holdLow;
endmodule

//--- dv/epi_properties.sv
// Port checks for the pin interrupt block
`timescale 1ns/1ps
module epi_properties (
    input wire clk,
    input wire resetn,
    input wire extIntPinN,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regRdData,
    input wire cpuIrqReq,
    input wire evtIrq
);
    // ----
    // Control register accesses
    // ----
    wire rdCtl = regRdEn && regAddr == 8'h1e;
    wire wrCtl = regWrEn && regAddr == 8'h1e;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_ack_zero: assert property (rdCtl |=> regRdData[7:4] == 4'h0 && !regRdData[2])
        else $error("ack reads 1");
    chk_unmapped_zero: assert property (regRdEn && regAddr > 8'h21 |=> regRdData == 8'h00)
        else $error("unmapped read");
    chk_rd_idle: assert property (!regRdEn |=> regRdData == 8'h00)
        else $error("stale read data");
    chk_pend_req: assert property (rdCtl |=> cpuIrqReq == (regRdData[3] && !regRdData[1]))
        else $error("request vs pending");
    chk_mask_blocks: assert property (wrCtl && regWrData[1] |=> ##1 !cpuIrqReq)
        else $error("masked request");
    chk_ctrl_back: assert property (wrCtl ##1 !regWrEn ##1 rdCtl |=> regRdData[1:0] == $past(regWrData[1:0], 3))
        else $error("ctrl readback");
    // Pin held low four cycles, so its falling edge is latched in the same cycle as the write
    chk_level_mode: assert property ((!extIntPinN)[*4] ##0 wrCtl && regWrData[2:0] == 3'h5 ##1 !extIntPinN && !regWrEn ##1 rdCtl && !extIntPinN |=> regRdData[3])
        else $error("level lost");
    chk_edge_only: assert property ((!extIntPinN)[*4] ##0 wrCtl && regWrData[2:0] == 3'h4 ##1 wrCtl && !extIntPinN ##1 !extIntPinN && !regWrEn ##1 rdCtl && !extIntPinN |=> !regRdData[3])
        else $error("ack ignored");
    cover property (rdCtl ##1 regRdData[3]);
    cover property ($rose(cpuIrqReq));
    cover property ($rose(evtIrq));
endmodule
bind epi_external_pin_interrupt_ctrl epi_properties chk (.clk(clk), .resetn(resetn),
    .extIntPinN(extIntPinN), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .cpuIrqReq(cpuIrqReq), .evtIrq(evtIrq));

//--- dv/tb_external_pin_interrupt_ctrl.sv
// Directed bench for the pin interrupt block
`timescale 1ns/1ps
module tb_external_pin_interrupt_ctrl;
    logic clk = 0, resetn = 0, holdLow = 0, regWrEn = 0, regRdEn = 0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
    wire pinN, cpuIrqReq, evtIrq;
    wire [7:0] regRdData;
    int bad_count = 0, comparisons = 0;
    always #20 clk = ~clk;
    epi_pin_src src (.clk(clk), .holdLow(holdLow), .pinN(pinN));
    epi_external_pin_interrupt_ctrl dut (.clk(clk), .resetn(resetn), .extIntPinN(pinN),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .cpuIrqReq(cpuIrqReq), .evtIrq(evtIrq));
    // Compare and count
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Holding the strobe n cycles gives n back-to-back writes
    task wr(input logic [7:0] a, input logic [7:0] d, input int n);
        @(posedge clk);
        regWrEn <= 1;
        regAddr <= a;
        regWrData <= d;
        repeat (n) @(posedge clk);
        regWrEn <= 0;
    endtask
    // Data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regRdEn <= 1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 0;
        @(negedge clk);
        check(regRdData, e);
    endtask
    // Filter plus latch need about five cycles
    task pin(input logic low);
        @(posedge clk);
        holdLow <= low;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1;
        rd(8'h1e, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h1e, 8'h07, 1);
        rd(8'h1e, 8'h03);
        wr(8'h21, 8'h03, 1);
        wr(8'h1e, 8'h00, 1);
        $display("access test ended");
        pin(1);
        check({7'h00, cpuIrqReq}, 8'h01);
        check({7'h00, evtIrq}, 8'h01);
        rd(8'h1e, 8'h08);
        pin(0);
        wr(8'h1e, 8'h04, 1);
        rd(8'h1e, 8'h00);
        check({7'h00, cpuIrqReq}, 8'h00);
        wr(8'h20, 8'h03, 1);
        rd(8'h20, 8'h00);
        check({7'h00, evtIrq}, 8'h00);
        $display("edge test ended");
        wr(8'h1e, 8'h02, 1);
        pin(1);
        check({7'h00, cpuIrqReq}, 8'h00);
        rd(8'h1e, 8'h0a);
        $display("mask test ended");
        wr(8'h1e, 8'h05, 1);
        rd(8'h1e, 8'h09);
        wr(8'h1e, 8'h04, 2);
        rd(8'h1e, 8'h00);
        rd(8'h20, 8'h03);
        check({7'h00, evtIrq}, 8'h01);
        $display("mode test ended");
        summarize;
    end
    // Watchdog well past the fewer than one hundred cycles needed
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        summarize;
    end
endmodule

//--- hdl/epi_defines.vh
// Constants for the external pin interrupt controller
`ifndef EPI_DEFINES_VH
`define EPI_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EPI_ADDR_W 8
`define EPI_ADDR_STATUS_CONTROL 8'h1e
`define EPI_ADDR_EVT_STATUS 8'h20
`define EPI_ADDR_EVT_MASK 8'h21

// ----------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------
`define EPI_BIT_MODE 0
`define EPI_BIT_MASK 1
`define EPI_BIT_ACK 2
`define EPI_BIT_PEND 3

// ----------------------------------------------------------------
// Event status field positions
// ----------------------------------------------------------------
`define EPI_EVT_LATCH 0
`define EPI_EVT_OVERRUN 1
`define EPI_EVT_W 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EPI_RST_CTRL 1'b0
`define EPI_RST_BYTE 8'h00
`define EPI_RST_EVT 2'h0
`define EPI_RST_SYNC 3'h7

`endif

//--- hdl/epi_external_pin_interrupt_ctrl.v
// External pin interrupt controller: pin latch, status/control register, event interrupt
`timescale 1ns/1ps
`include "epi_defines.vh"

// What this block does
// (RULE_01) Read-only pending flag reads 1 while a pin request is latched.
// (RULE_02) Writing 1 to the acknowledge bit clears the pin latch.
// (RULE_03) Acknowledge bit always reads 0; reset clears it.
// (RULE_04) Mask bit 1 suppresses the CPU request; reset clears it.
// (RULE_05) Trigger select 1: requests on falling edges and while pin is low.
// (RULE_06) Trigger select 0: falling edges only; reset clears it.
// (RULE_07) Status and control register lives at address 001E.
// (RULE_08) Latch set on qualifying event; request only while latched and unmasked.
module epi_external_pin_interrupt_ctrl (
    input wire clk,
    input wire resetn,
    input wire extIntPinN,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [7:0] regRdData,
    output reg cpuIrqReq,
    output reg evtIrq
);

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    reg [2:0] pinSync_q;
    reg pinState_q;

    // Three flops; a change counts once stages two and three agree
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinSync_q <= `EPI_RST_SYNC;
        end else begin
            pinSync_q <= {pinSync_q[1:0], extIntPinN};
        end
    end

    // Filtered pin level, held high (idle) from reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinState_q <= 1'b1;
        end else if (pinSync_q[1] == pinSync_q[2]) begin
            pinState_q <= pinSync_q[2];
        end
    end

    // ----------------------------------------------------------------
    // Control state
    // ----------------------------------------------------------------
    reg ext_int_request_mask_q;
    reg modeLevel_q;
    reg ext_int_pending_flag_q;
    reg [`EPI_EVT_W-1:0] evtStatus_q;
    reg [`EPI_EVT_W-1:0] evtMask_q;

    wire pinFilt;
    wire fallEdge;
    wire pinEvent;
    wire ctrlWr;
    wire ackWr;
    wire [`EPI_EVT_W-1:0] evtSet;

    // Address match helper, reused by read and write decoding
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Filtered level is the settled sync output; edge taken against held state
    assign pinFilt = (pinSync_q[1] == pinSync_q[2]) ? pinSync_q[2] : pinState_q;
    assign fallEdge = pinState_q & ~pinFilt; // [RULE_06]
    // Level mode also keeps requesting while the pin stays low
    assign pinEvent = fallEdge | (modeLevel_q & ~pinFilt); // [RULE_05]
    assign ctrlWr = regWrEn & hit(regAddr, `EPI_ADDR_STATUS_CONTROL); // [RULE_07]
    assign ackWr = ctrlWr & regWrData[`EPI_BIT_ACK];

    // Events for the sticky status: latch set, and a request while already pending
    assign evtSet[`EPI_EVT_LATCH] = pinEvent & ~ext_int_pending_flag_q;
    assign evtSet[`EPI_EVT_OVERRUN] = pinEvent & ext_int_pending_flag_q & ~ackWr;

    // Mask and trigger select, software owned
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_int_request_mask_q <= `EPI_RST_CTRL; // [RULE_04]
            modeLevel_q <= `EPI_RST_CTRL; // [RULE_06]
        end else if (ctrlWr) begin
            ext_int_request_mask_q <= regWrData[`EPI_BIT_MASK]; // [RULE_04]
            modeLevel_q <= regWrData[`EPI_BIT_MODE]; // [RULE_05]
        end
    end

    // Pin latch; a new event in the ack cycle wins so nothing is lost.
    // In level mode a held-low pin keeps the latch set through an ack.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_int_pending_flag_q <= 1'b0;
        end else if (pinEvent) begin
            ext_int_pending_flag_q <= 1'b1; // [RULE_08]
        end else if (ackWr) begin
            ext_int_pending_flag_q <= 1'b0; // [RULE_02]
        end
    end

    // ----------------------------------------------------------------
    // Sticky event status and mask
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `EPI_EVT_W; gi = gi + 1) begin : gEvt
            // Set beats write-one-to-clear in the same cycle
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    evtStatus_q[gi] <= 1'b0;
                end else if (evtSet[gi]) begin
                    evtStatus_q[gi] <= 1'b1;
                end else if (regWrEn && hit(regAddr, `EPI_ADDR_EVT_STATUS) &&
                        regWrData[gi]) begin
                    evtStatus_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Event mask: 1 lets the status bit reach the event interrupt
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evtMask_q <= `EPI_RST_EVT;
        end else if (regWrEn && hit(regAddr, `EPI_ADDR_EVT_MASK)) begin
            evtMask_q <= regWrData[`EPI_EVT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Outputs and read port
    // ----------------------------------------------------------------
    reg [7:0] rdMux;

    // Read mux; unmapped addresses and reserved bits read zero
    always @* begin
        rdMux = `EPI_RST_BYTE;
        if (hit(regAddr, `EPI_ADDR_STATUS_CONTROL)) begin
            rdMux[`EPI_BIT_PEND] = ext_int_pending_flag_q; // [RULE_01]
            rdMux[`EPI_BIT_ACK] = 1'b0; // [RULE_03]
            rdMux[`EPI_BIT_MASK] = ext_int_request_mask_q;
            rdMux[`EPI_BIT_MODE] = modeLevel_q;
        end else if (hit(regAddr, `EPI_ADDR_EVT_STATUS)) begin
            rdMux[`EPI_EVT_W-1:0] = evtStatus_q;
        end else if (hit(regAddr, `EPI_ADDR_EVT_MASK)) begin
            rdMux[`EPI_EVT_W-1:0] = evtMask_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= `EPI_RST_BYTE;
        end else if (regRdEn) begin
            regRdData <= rdMux;
        end else begin
            regRdData <= `EPI_RST_BYTE;
        end
    end

    // Registered outputs; one cycle behind the state that drives them
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpuIrqReq <= 1'b0;
            evtIrq <= 1'b0;
        end else begin
            cpuIrqReq <= ext_int_pending_flag_q & ~ext_int_request_mask_q; // [RULE_04] [RULE_08]
            evtIrq <= |(evtStatus_q & evtMask_q);
        end
    end

endmodule
